/* hw/sfs_pkg.sv */
// Package and holding-register bank of the self-program flash sequencer
`timescale 1ns/1ps
`default_nettype none

package sfs_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned PROG_TIME_US = 2000;
    localparam int unsigned PROG_TIME_CYC = PROG_TIME_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_KEY = 3'h1;
    localparam logic [2:0] REG_LATCH = 3'h2;
    localparam logic [2:0] REG_PTR_L = 3'h3;
    localparam logic [2:0] REG_PTR_H = 3'h4;
    localparam logic [2:0] REG_PTR_U = 3'h5;
    localparam logic [2:0] REG_TOP = 3'h6;
    localparam logic [2:0] REG_STAT = 3'h7;

    // Memory control and status bit positions
    localparam int unsigned CTRL_PSEL = 7;
    localparam int unsigned CTRL_CSEL = 6;
    localparam int unsigned CTRL_ERASE = 4;
    localparam int unsigned CTRL_ABORT = 3;
    localparam int unsigned CTRL_PEN = 2;
    localparam int unsigned CTRL_GO = 1;
    localparam int unsigned STAT_DONE = 0;

    // Table operation register fields
    localparam int unsigned TOP_STORE = 2;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_POSTDEC = 2'h2;
    localparam logic [1:0] MODE_PREINC = 2'h3;

    // ----------------------------------------------------------------
    // Values and geometry
    // ----------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int unsigned PTR_W = 22;
    localparam int unsigned PTR_STEP_W = 21;
    localparam int unsigned HOLD_N = 32;
    localparam int unsigned HOLD_IDX_W = 5;
    localparam int unsigned ERASE_LSB = 6;
    localparam int unsigned PROG_LSB = 5;
    localparam logic [4:0] HOLD_LAST = 5'h1F;

    // Request to the flash array
    typedef struct packed {
        logic erase;
        logic prog;
        logic [PTR_W-1:0] addr;
        logic [7:0] data;
    } sfs_flash_req_t;

    typedef enum logic [1:0] {SFS_IDLE, SFS_ERASE, SFS_PROG} sfs_state_t;
    typedef enum logic [1:0] {SFS_KEY_NONE, SFS_KEY_HALF, SFS_KEY_ARMED} sfs_key_t;
endpackage : sfs_pkg

module sfs_hold_bank (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic wr_en_i,
    input wire logic [sfs_pkg::HOLD_IDX_W-1:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic clr_all_i,
    input wire logic [sfs_pkg::HOLD_IDX_W-1:0] rd_idx_i,
    output logic [7:0] rd_data_o
);
    import sfs_pkg::*;

    logic [7:0] mem_q [HOLD_N];

    // ----------------------------------------------------------------
    // One byte-wide holding register per entry
    // ----------------------------------------------------------------
    for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
        always_ff @(posedge clk_i) begin
            if (srst_i || clr_all_i) begin
                mem_q[i] <= BYTE_ERASED;
            end else if (wr_en_i && (wr_idx_i == HOLD_IDX_W'(i))) begin
                mem_q[i] <= wr_data_i;
            end
        end
    end

    // Read port for the program walk
    assign rd_data_o = mem_q[rd_idx_i];
endmodule : sfs_hold_bank

`default_nettype wire

/* hw/sfs_sequencer.sv */
// Self-program flash sequencer: table access, unlock, row erase and row program
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sfs_sequencer #(
    parameter int unsigned PROG_CYCLES = sfs_pkg::PROG_TIME_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [sfs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [sfs_pkg::PTR_W-2:0] flash_rd_addr_o,
    input wire logic [15:0] flash_rd_data_i,
    output sfs_pkg::sfs_flash_req_t flash_req_o,
    output logic core_stall_o,
    output logic completion_irq_flag_o
);
    import sfs_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sfs_state_t state_q;
    sfs_key_t key_q;
    logic [PTR_W-1:0] table_pointer_q;
    logic [7:0] table_byte_latch_q;
    logic program_space_select_q;
    logic config_space_select_q;
    logic row_erase_sel_q;
    logic abort_flag_q;
    logic program_enable_q;
    logic go_q;
    logic completion_irq_flag_q;
    logic fetch_pend_q;
    logic fetch_hi_q;
    logic [31:0] timer_q;
    logic [HOLD_IDX_W-1:0] walk_idx_q;
    logic walk_on_q;
    logic [7:0] rdata_q;
    logic [PTR_W-2:0] flash_rd_addr_q;
    sfs_flash_req_t flash_req_q;
    logic stall_q;
    logic rst_seen_q;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic busy;
    logic wr_ctrl;
    logic wr_key;
    logic wr_top;
    logic go_set;
    logic start_ok;
    logic timer_done;
    logic [1:0] top_mode;
    logic top_store;
    logic [PTR_W-1:0] ptr_inc;
    logic [PTR_W-1:0] ptr_dec;
    logic [PTR_W-1:0] ptr_eff;
    logic [7:0] hold_byte;

    assign busy = (state_q != SFS_IDLE);
    assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL) && !busy;
    assign wr_key = reg_wr_i && (reg_addr_i == REG_KEY);
    assign wr_top = reg_wr_i && (reg_addr_i == REG_TOP) && !busy;
    assign top_mode = reg_wdata_i[1:0];
    assign top_store = reg_wdata_i[TOP_STORE];
    assign go_set = wr_ctrl && reg_wdata_i[CTRL_GO] && !go_q;
    // key and target must both be right; armed only right after key
    assign start_ok = (key_q == SFS_KEY_ARMED) && reg_wdata_i[CTRL_PSEL] && !reg_wdata_i[CTRL_CSEL];
    // length taken from the on-chip timer only
    assign timer_done = (timer_q == (PROG_CYCLES - 32'd1));

    // Pointer stepping touches only the low 21 bits
    assign ptr_inc = {table_pointer_q[PTR_W-1], table_pointer_q[PTR_STEP_W-1:0] + 21'h1};
    assign ptr_dec = {table_pointer_q[PTR_W-1], table_pointer_q[PTR_STEP_W-1:0] - 21'h1};
    assign ptr_eff = (top_mode == MODE_PREINC) ? ptr_inc : table_pointer_q;

    // ----------------------------------------------------------------
    // Holding registers
    // ----------------------------------------------------------------
    // table stores only load the holding bank
    sfs_hold_bank u_hold (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .wr_en_i(wr_top && top_store),
        .wr_idx_i(ptr_eff[HOLD_IDX_W-1:0]),
        .wr_data_i(table_byte_latch_q),
        // bank back to FFh after a program cycle
        .clr_all_i((state_q == SFS_PROG) && timer_done),
        .rd_idx_i(walk_idx_q),
        .rd_data_o(hold_byte)
    );

    // ----------------------------------------------------------------
    // Unlock key tracking
    // ----------------------------------------------------------------
    // any access other than the next key step cancels
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            key_q <= SFS_KEY_NONE;
        end else if (reg_wr_i || reg_rd_i) begin
            if (wr_key && (reg_wdata_i == KEY_FIRST)) begin
                key_q <= SFS_KEY_HALF;
            end else if (wr_key && (key_q == SFS_KEY_HALF) && (reg_wdata_i == KEY_SECOND)) begin
                key_q <= SFS_KEY_ARMED;
            end else begin
                key_q <= SFS_KEY_NONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer and timer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= SFS_IDLE;
            stall_q <= 1'b0;
            timer_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                SFS_IDLE: begin
                    timer_q <= 32'h0000_0000;
                    if (go_set && program_enable_q && start_ok) begin
                        // erase select picks a row erase
                        state_q <= reg_wdata_i[CTRL_ERASE] ? SFS_ERASE : SFS_PROG;
                        stall_q <= 1'b1;
                    end
                end
                default: begin
                    // long cycle ends on the timer
                    timer_q <= timer_q + 32'h0000_0001;
                    if (timer_done) begin
                        state_q <= SFS_IDLE;
                        stall_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Program walk over the holding bank
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            walk_idx_q <= 5'h00;
            walk_on_q <= 1'b0;
        end else if (state_q != SFS_PROG) begin
            walk_idx_q <= 5'h00;
            walk_on_q <= 1'b1;
        end else if (walk_on_q) begin
            walk_idx_q <= walk_idx_q + 5'h01;
            walk_on_q <= (walk_idx_q != HOLD_LAST);
        end
    end

    // ----------------------------------------------------------------
    // Flash array requests
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flash_req_q <= '0;
        end else begin
            // whole 64-byte block, low six bits forced off
            flash_req_q.erase <= (state_q == SFS_ERASE) && !timer_done;
            // bytes of FFh issue no program pulse
            flash_req_q.prog <= (state_q == SFS_PROG) && walk_on_q && (hold_byte != BYTE_ERASED);
            if (state_q == SFS_ERASE) begin
                flash_req_q.addr <= {table_pointer_q[PTR_W-1:ERASE_LSB], 6'h00};
                flash_req_q.data <= BYTE_ERASED;
            end else begin
                flash_req_q.addr <= {table_pointer_q[PTR_W-1:PROG_LSB], walk_idx_q};
                flash_req_q.data <= hold_byte;
            end
        end
    end

    // ----------------------------------------------------------------
    // Table pointer and table fetch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            table_pointer_q <= '0;
        end else if (!busy && reg_wr_i && (reg_addr_i == REG_PTR_L)) begin
            table_pointer_q[7:0] <= reg_wdata_i;
        end else if (!busy && reg_wr_i && (reg_addr_i == REG_PTR_H)) begin
            table_pointer_q[15:8] <= reg_wdata_i;
        end else if (!busy && reg_wr_i && (reg_addr_i == REG_PTR_U)) begin
            table_pointer_q[PTR_W-1:16] <= reg_wdata_i[PTR_W-17:0];
        end else if (wr_top) begin
            // optional pointer step around the table access
            if (top_mode == MODE_POSTINC || top_mode == MODE_PREINC) begin
                table_pointer_q <= ptr_inc;
            end else if (top_mode == MODE_POSTDEC) begin
                table_pointer_q <= ptr_dec;
            end
        end
    end

    // Fetch issues a word read, byte chosen next cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fetch_pend_q <= 1'b0;
            fetch_hi_q <= 1'b0;
            flash_rd_addr_q <= '0;
        end else begin
            fetch_pend_q <= wr_top && !top_store;
            if (wr_top && !top_store) begin
                flash_rd_addr_q <= ptr_eff[PTR_W-1:1];
                // bit 0 selects the byte of the word
                fetch_hi_q <= ptr_eff[0];
            end
        end
    end

    // fetched byte lands in the table byte latch
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            table_byte_latch_q <= BYTE_ZERO;
        end else if (fetch_pend_q) begin
            table_byte_latch_q <= fetch_hi_q ? flash_rd_data_i[15:8] : flash_rd_data_i[7:0];
        end else if (!busy && reg_wr_i && (reg_addr_i == REG_LATCH)) begin
            table_byte_latch_q <= reg_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Memory control bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            program_space_select_q <= 1'b0;
            config_space_select_q <= 1'b0;
            program_enable_q <= 1'b0;
        end else if (wr_ctrl) begin
            // target and enable come from software
            program_space_select_q <= reg_wdata_i[CTRL_PSEL];
            config_space_select_q <= reg_wdata_i[CTRL_CSEL];
            program_enable_q <= reg_wdata_i[CTRL_PEN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            row_erase_sel_q <= 1'b0;
        end else if ((state_q == SFS_ERASE) && timer_done) begin
            // erase select drops when erase ends
            row_erase_sel_q <= 1'b0;
        end else if (wr_ctrl) begin
            row_erase_sel_q <= reg_wdata_i[CTRL_ERASE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            go_q <= 1'b0;
        end else if (busy && timer_done) begin
            // hardware clears go at the end
            go_q <= 1'b0;
        end else if (go_set && program_enable_q && start_ok) begin
            go_q <= 1'b1;
        end
    end

    // Reset level one edge ago, tells a held reset from its first edge
    always_ff @(posedge clk_i) begin
        rst_seen_q <= srst_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // reset during a long cycle leaves the abort flag set
            if (busy) begin
                abort_flag_q <= 1'b1;
            end else if (rst_seen_q) begin
                abort_flag_q <= abort_flag_q; // Keep the mark through a long reset
            end else begin
                abort_flag_q <= 1'b0;
            end
        end else if (go_set && program_enable_q && !start_ok) begin
            abort_flag_q <= 1'b1;
        end else if (busy && timer_done) begin
            abort_flag_q <= 1'b0;
        end else if (wr_ctrl) begin
            abort_flag_q <= reg_wdata_i[CTRL_ABORT];
        end
    end

    // sticky completion flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            completion_irq_flag_q <= 1'b0;
        end else if (busy && timer_done) begin
            completion_irq_flag_q <= 1'b1;
        end else if (reg_wr_i && (reg_addr_i == REG_STAT) && reg_wdata_i[STAT_DONE]) begin
            completion_irq_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i || !reg_rd_i) begin
            rdata_q <= BYTE_ZERO;
        end else if (reg_addr_i == REG_CTRL) begin
            rdata_q <= {program_space_select_q, config_space_select_q, 1'b0, row_erase_sel_q,
                        abort_flag_q, program_enable_q, go_q, 1'b0};
        end else if (reg_addr_i == REG_LATCH) begin
            rdata_q <= table_byte_latch_q;
        end else if (reg_addr_i == REG_PTR_L) begin
            rdata_q <= table_pointer_q[7:0];
        end else if (reg_addr_i == REG_PTR_H) begin
            rdata_q <= table_pointer_q[15:8];
        end else if (reg_addr_i == REG_PTR_U) begin
            rdata_q <= {2'b00, table_pointer_q[PTR_W-1:16]};
        end else if (reg_addr_i == REG_STAT) begin
            rdata_q <= {7'h00, completion_irq_flag_q};
        end else begin
            rdata_q <= BYTE_ZERO; // Key port and table op read zero
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // stall straight from its own flop
    assign core_stall_o = stall_q;
    assign reg_rdata_o = rdata_q;
    assign flash_rd_addr_o = flash_rd_addr_q;
    assign flash_req_o = flash_req_q;
    assign completion_irq_flag_o = completion_irq_flag_q;
endmodule : sfs_sequencer

`default_nettype wire

/* testbench/sfs_sequencer_props.sv */
// Port checker of the self-program flash sequencer
`timescale 1ns/1ps
`default_nettype none

module sfs_sequencer_props #(
    parameter int unsigned PROG_CYCLES = 64
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [sfs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [sfs_pkg::PTR_W-2:0] flash_rd_addr_o,
    input wire logic [15:0] flash_rd_data_i,
    input wire sfs_pkg::sfs_flash_req_t flash_req_o,
    input wire logic core_stall_o,
    input wire logic completion_irq_flag_o
);
    import sfs_pkg::*;
    int unsigned stall_cnt_q;

    // Counts cycles of the current stall
    always_ff @(posedge clk_i) begin
        if (srst_i || !core_stall_o) begin
            stall_cnt_q <= 0;
        end else begin
            stall_cnt_q <= stall_cnt_q + 1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Long cycle ends: stall high then low
    sequence s_end;
        core_stall_o ##1 !core_stall_o;
    endsequence
    sequence s_go_wr;
        $past(reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_GO]);
    endsequence

    property p_stall_len;
        s_end |-> stall_cnt_q == PROG_CYCLES;
    endproperty
    property p_stall_max;
        core_stall_o |-> stall_cnt_q < PROG_CYCLES;
    endproperty
    property p_done;
        s_end |-> ##[0:1] completion_irq_flag_o;
    endproperty
    property p_start;
        $rose(core_stall_o) |-> s_go_wr;
    endproperty
    property p_erase_stall;
        flash_req_o.erase |-> core_stall_o && !flash_req_o.prog;
    endproperty
    property p_erase_align;
        flash_req_o.erase |-> flash_req_o.addr[ERASE_LSB-1:0] == 6'h00;
    endproperty
    property p_prog_skip;
        flash_req_o.prog |-> core_stall_o && flash_req_o.data != BYTE_ERASED;
    endproperty
    property p_flag_hold;
        completion_irq_flag_o && !(reg_wr_i && reg_addr_i == REG_STAT && reg_wdata_i[STAT_DONE])
            |=> completion_irq_flag_o;
    endproperty
    property p_rdata_idle;
        !reg_rd_i |=> reg_rdata_o == BYTE_ZERO;
    endproperty

    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    a_stall_max: assert property (p_stall_max) else $error("stall too long");
    a_done: assert property (p_done) else $error("completion flag not set");
    a_start: assert property (p_start) else $error("stall without go write");
    a_erase_stall: assert property (p_erase_stall) else $error("erase outside stall");
    a_erase_align: assert property (p_erase_align) else $error("erase address not block aligned");
    a_prog_skip: assert property (p_prog_skip) else $error("bad program pulse");
    a_flag_hold: assert property (p_flag_hold) else $error("completion flag lost");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
endmodule : sfs_sequencer_props

bind sfs_sequencer sfs_sequencer_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .flash_rd_addr_o(flash_rd_addr_o),
    .flash_rd_data_i(flash_rd_data_i),
    .flash_req_o(flash_req_o),
    .core_stall_o(core_stall_o),
    .completion_irq_flag_o(completion_irq_flag_o)
);
`default_nettype wire

/* testbench/sfs_flash_model.sv */
// Program flash array model: word read, row erase, AND programming
`timescale 1ns/1ps
`default_nettype none

module sfs_flash_model (
    input wire logic clk_i,
    input wire logic [sfs_pkg::PTR_W-2:0] rd_addr_i,
    output logic [15:0] rd_data_o,
    input wire sfs_pkg::sfs_flash_req_t req_i
);
    import sfs_pkg::*;
    logic [7:0] mem [256];
    logic erase_q;

    // Known start pattern
    initial begin
        erase_q = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end

    // odd byte high, word ready in the cycle of its address
    assign rd_data_o = {mem[{rd_addr_i[6:0], 1'b1}], mem[{rd_addr_i[6:0], 1'b0}]};

    always @(posedge clk_i) begin
        erase_q <= req_i.erase;
        if (req_i.erase && !erase_q) begin
            for (int i = 0; i < 64; i++) begin
                mem[{req_i.addr[7:6], 6'(i)}] <= BYTE_ERASED;
            end
        end
        if (req_i.prog) begin
            mem[req_i.addr[7:0]] <= mem[req_i.addr[7:0]] & req_i.data;
        end
    end
endmodule : sfs_flash_model
`default_nettype wire

/* testbench/sfs_sequencer_tb_top.sv */
// Self-checking bench of the self-program flash sequencer
`timescale 1ns/1ps
`default_nettype none

module sfs_sequencer_tb_top;
    import sfs_pkg::*;
    localparam int unsigned NCYC = 64;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [PTR_W-2:0] fa;
    logic [15:0] fd;
    sfs_flash_req_t req;
    logic stall;
    logic flag;
    logic [7:0] sh [256];
    logic [7:0] v;
    logic [7:0] b;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int np = 0;
    int ne;
    int p;
    int n;

    sfs_sequencer #(.PROG_CYCLES(NCYC)) dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .flash_rd_addr_o(fa),
        .flash_rd_data_i(fd), .flash_req_o(req), .core_stall_o(stall), .completion_irq_flag_o(flag));
    sfs_flash_model u_flash (.clk_i(clk_i), .rd_addr_i(fa), .rd_data_o(fd), .req_i(req));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Hang limit and program pulse count
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (req.prog === 1'b1) np++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic set_ptr(input logic [7:0] x);
        wr_reg(REG_PTR_L, x);
        p = x;
    endtask : set_ptr
    task automatic fetch(input logic [1:0] m);
        if (m == MODE_PREINC) p++;
        wr_reg(REG_TOP, {6'h00, m});
        rd_reg(REG_LATCH, v);
        chk(v, sh[p]);
        if (m == MODE_POSTINC) p++;
        if (m == MODE_POSTDEC) p--;
    endtask : fetch
    task automatic start(input logic [7:0] ctl);
        // selects, erase and enable as in ctl, go bit clear, before the key
        wr_reg(REG_CTRL, ctl & 8'hFD);
        wr_reg(REG_KEY, KEY_FIRST);
        wr_reg(REG_KEY, KEY_SECOND);
        wr_reg(REG_CTRL, ctl);
    endtask : start
    task automatic wait_end(output int c);
        c = 0;
        repeat (2 * NCYC) begin
            #1;
            if (stall === 1'b1) c++;
            @(posedge clk_i);
        end
    endtask : wait_end
    task automatic complete_run();
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        void'($urandom(32'h098c));
        for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'h5A;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_reg(REG_CTRL, v);
        chk(v, 8'h00);
        // Upper pointer bytes
        b = 8'($urandom);
        wr_reg(REG_PTR_H, b);
        rd_reg(REG_PTR_H, v);
        chk(v, b);
        wr_reg(REG_PTR_U, 8'hFF);
        rd_reg(REG_PTR_U, v);
        chk(v, 8'h3F);
        // Fetches in every pointer mode
        set_ptr(8'h40 + 8'($urandom_range(0, 127)));
        for (int k = 0; k < 24; k++) fetch(k < 4 ? 2'(k) : 2'($urandom));
        rd_reg(REG_PTR_L, v);
        chk(v, p[7:0]);
        // Row erase from a mid-block pointer
        set_ptr(8'h80 + 8'($urandom_range(1, 63)));
        start(8'h96);
        wait_end(n);
        chk(n, NCYC);
        chk(flag, 1'b1);
        rd_reg(REG_STAT, v);
        chk(v[0], 1'b1);
        rd_reg(REG_CTRL, v);
        chk({v[4], v[3], v[1]}, 3'b000);
        for (int i = 128; i < 192; i++) sh[i] = BYTE_ERASED;
        wr_reg(REG_STAT, 8'h01);
        rd_reg(REG_STAT, v);
        chk(v[0], 1'b0);
        chk(flag, 1'b0);
        set_ptr(8'h7E);
        repeat (4) fetch(MODE_POSTINC);
        set_ptr(8'hBE);
        repeat (4) fetch(MODE_POSTINC);
        // Partial row program over unerased data
        set_ptr(8'h20);
        ne = 0;
        for (int i = 0; i < 32; i++) begin
            b = ($urandom_range(0, 2) == 0) ? BYTE_ERASED : 8'($urandom);
            if (b != BYTE_ERASED) ne++;
            wr_reg(REG_LATCH, b);
            wr_reg(REG_TOP, {5'h00, 1'b1, MODE_POSTINC});
            sh[32 + i] = sh[32 + i] & b;
        end
        set_ptr(8'h20);
        np = 0;
        start(8'h86);
        wait_end(n);
        chk(n, NCYC);
        chk(np, ne);
        set_ptr(8'h1F);
        repeat (34) fetch(MODE_POSTINC);
        // Bank back to erased value
        np = 0;
        start(8'h86);
        wait_end(n);
        chk(np, 0);
        // Key broken by a read
        wr_reg(REG_KEY, KEY_FIRST);
        rd_reg(REG_STAT, v);
        wr_reg(REG_KEY, KEY_SECOND);
        wr_reg(REG_CTRL, 8'h86);
        wait_end(n);
        chk(n, 0);
        rd_reg(REG_CTRL, v);
        chk(v[3], 1'b1);
        // Go with enable clear
        start(8'h82);
        wait_end(n);
        chk(n, 0);
        // Reset during a long cycle
        start(8'h86);
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_reg(REG_CTRL, v);
        chk({stall, v[3]}, 2'b01);
        complete_run();
    end
endmodule : sfs_sequencer_tb_top
`default_nettype wire
